/* design/etc_core.sv */
`timescale 1ns/1ps

// Behaviour
// - Counter and compare are 8-bit registers
// - Every timer request shows in flag register
// - Per-source mask gates each request
// - Tick from prescaler or external pin
// - Clock select picks source and edge
// - Select zero stops and holds counter
// - CPU reads/writes counter anytime
// - CPU counter write beats tick
// - Tick clears, increments or decrements counter
// - Direction select, top and bottom indications
// - Bottom is 0x00
// - Maximum is 0xFF
// - Top is maximum or compare, per mode
// - Waveform mode bits set count sequence
// - Continuous compare drives output pin
// - Compare match sets compare flag
// - Overflow flag set where mode defines
// - Compare flag set on following tick
// - Normal: up, wrap, overflow at zero
// - Mode 2 clears counter on match
// - Counter write blocks next tick's match
module etc_core (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // External count pin, asynchronous
    input wire logic extCountPin,
    // Counter write port
    input wire logic cntWrEn,
    input wire logic [7:0] cntWrData,
    // Compare write port
    input wire logic cmpWrEn,
    input wire logic [7:0] cmpWrData,
    // Control register write port
    input wire logic ctrlWrEn,
    input wire etc_pkg::etc_ctrl_t ctrlWrData,
    // Mask register write port
    input wire logic maskWrEn,
    input wire etc_pkg::etc_flags_t maskWrData,
    // Flag clear port, write one to clear
    input wire logic flagClrEn,
    input wire etc_pkg::etc_flags_t flagClrData,
    // Register readback
    output logic [7:0] counterValue,
    output logic [7:0] compareValue,
    output etc_pkg::etc_ctrl_t timerControlReg,
    output etc_pkg::etc_flags_t timerMaskReg,
    output etc_pkg::etc_flags_t timerFlagReg,
    // Counter status
    output logic countDown,
    output logic topReached,
    output logic bottomReached,
    // Interrupt requests
    output logic overflowIrq,
    output logic compareIrq,
    // Waveform pin
    output logic compareOutputPin
);
    import etc_pkg::*;

    // Whole state of the timer
    typedef struct packed {
        logic [7:0] counter;    // Live count
        logic [7:0] compare;    // Active compare value
        logic [7:0] compareBuf; // CPU-side compare buffer
        etc_ctrl_t ctrl;        // Control fields
        etc_flags_t mask;       // Interrupt masks
        etc_flags_t flags;      // Sticky flags
        logic dirDown;          // Counting down
        logic blockMatch;       // Match suppressed next tick
        logic pinOut;           // Waveform output level
        logic topInd;           // Counter at top
        logic bottomInd;        // Counter at bottom
        logic ovfIrq;           // Masked overflow request
        logic cmpIrq;           // Masked compare request
    } etc_core_state_t;

    etc_core_state_t q;
    etc_core_state_t d;

    // Prescaler enables
    etc_pre_ticks_t preTicks;

    // Synchronised pin edges
    logic extRise;
    logic extFall;

    // Combinational helpers
    logic tick;
    logic eqNow;
    logic matchEvt;
    logic ovfEvt;
    logic atMax;
    logic atBottom;
    logic [7:0] topVal;
    etc_flags_t clrMask;
    etc_flags_t setMask;

    // Divider for internal clock sources
    etc_prescaler #(
        .PreW(PRE_W)
    ) u_prescaler (
        .core_clk(core_clk),
        .nrst(nrst),
        .preTicks(preTicks)
    );

    // Pin synchroniser and edge detector
    etc_edge_sync u_edge_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .pinIn(extCountPin),
        .riseEvt(extRise),
        .fallEvt(extFall)
    );

    // Pick the timer tick from the select field
    function automatic logic tickSel(input etc_clksel_t cs,
                                     input etc_pre_ticks_t pt,
                                     input logic rise,
                                     input logic fall);
        unique case (cs)
            CS_STOP: tickSel = 1'b0;
            CS_DIV1: tickSel = 1'b1;
            CS_DIV8: tickSel = pt.div8;
            CS_DIV64: tickSel = pt.div64;
            CS_DIV256: tickSel = pt.div256;
            CS_DIV1024: tickSel = pt.div1024;
            CS_EXT_FALL: tickSel = fall;
            CS_EXT_RISE: tickSel = rise;
        endcase
    endfunction : tickSel

    // PWM modes double buffer the compare value
    function automatic logic isPwm(input etc_wmode_t wm);
        isPwm = (wm == WM_PHASE_PWM) || (wm == WM_FAST_PWM);
    endfunction : isPwm

    // Highest value of the count sequence
    function automatic logic [7:0] topOf(input etc_wmode_t wm,
                                         input logic [7:0] cmp);
        if (wm == WM_CLEAR_ON_COMPARE) begin
            topOf = cmp;
        end else begin
            topOf = CNT_MAX;
        end
    endfunction : topOf

    // Next-state logic
    always_comb begin
        d = q;
        // Tick source and edge
        tick = tickSel(q.ctrl.clockSelect, preTicks,
                       extRise, extFall);
        // Comparator runs every cycle
        eqNow = (q.counter == q.compare);
        atMax = (q.counter == CNT_MAX);
        atBottom = (q.counter == CNT_BOTTOM);
        matchEvt = 1'b0;
        ovfEvt = 1'b0;

        // Control and mask writes
        if (ctrlWrEn) begin
            d.ctrl = ctrlWrData;
        end
        if (maskWrEn) begin
            d.mask = maskWrData;
        end

        // Compare write: buffered in PWM, direct otherwise
        if (cmpWrEn) begin
            d.compareBuf = cmpWrData;
            if (!isPwm(q.ctrl.waveformMode)) begin
                d.compare = cmpWrData;
            end
        end

        // Direction only used by the dual-slope mode
        if (q.ctrl.waveformMode != WM_PHASE_PWM) begin
            d.dirDown = 1'b0;
        end

        // Counting on a timer tick
        if (tick) begin
            // Equality seen before this tick sets the flag now
            matchEvt = eqNow && !q.blockMatch;
            d.blockMatch = 1'b0;
            unique case (q.ctrl.waveformMode)
                WM_NORMAL: begin
                    // Up only, wraps past maximum
                    d.counter = q.counter + CNT_ONE;
                    ovfEvt = atMax;
                end
                WM_CLEAR_ON_COMPARE: begin
                    if (eqNow) begin
                        d.counter = CNT_BOTTOM;
                    end else begin
                        d.counter = q.counter + CNT_ONE;
                    end
                    // Overflow only if the count passes maximum
                    ovfEvt = atMax && !eqNow;
                end
                WM_FAST_PWM: begin
                    if (atMax) begin
                        // Restart and load buffered compare
                        d.counter = CNT_BOTTOM;
                        d.compare = q.compareBuf;
                        ovfEvt = 1'b1;
                    end else begin
                        d.counter = q.counter + CNT_ONE;
                    end
                end
                WM_PHASE_PWM: begin
                    if (!q.dirDown) begin
                        if (atMax) begin
                            // Turn at top, load buffer
                            d.dirDown = 1'b1;
                            d.counter = q.counter - CNT_ONE;
                            d.compare = q.compareBuf;
                        end else begin
                            d.counter = q.counter + CNT_ONE;
                        end
                    end else begin
                        if (atBottom) begin
                            // Turn at bottom, overflow here
                            d.dirDown = 1'b0;
                            d.counter = q.counter + CNT_ONE;
                            ovfEvt = 1'b1;
                        end else begin
                            d.counter = q.counter - CNT_ONE;
                        end
                    end
                end
            endcase

            // Waveform pin response to match and bottom
            unique case (q.ctrl.waveformMode)
                WM_NORMAL, WM_CLEAR_ON_COMPARE: begin
                    if (matchEvt) begin
                        unique case (q.ctrl.outMode)
                            OM_OFF: d.pinOut = q.pinOut;
                            OM_TOGGLE: d.pinOut = ~q.pinOut;
                            OM_CLEAR: d.pinOut = 1'b0;
                            OM_SET: d.pinOut = 1'b1;
                        endcase
                    end
                end
                WM_FAST_PWM: begin
                    // Match edge, then restore at bottom
                    if (q.ctrl.outMode == OM_CLEAR) begin
                        if (atMax) begin
                            d.pinOut = 1'b1;
                        end else if (matchEvt) begin
                            d.pinOut = 1'b0;
                        end
                    end else if (q.ctrl.outMode == OM_SET) begin
                        if (atMax) begin
                            d.pinOut = 1'b0;
                        end else if (matchEvt) begin
                            d.pinOut = 1'b1;
                        end
                    end
                end
                WM_PHASE_PWM: begin
                    // Level follows slope on match
                    if (matchEvt) begin
                        if (q.ctrl.outMode == OM_CLEAR) begin
                            d.pinOut = q.dirDown;
                        end else if (q.ctrl.outMode == OM_SET) begin
                            d.pinOut = ~q.dirDown;
                        end
                    end
                end
            endcase
        end

        // CPU write wins over tick, blocks next match
        if (cntWrEn) begin
            d.counter = cntWrData;
            d.blockMatch = 1'b1;
        end

        // Sticky flags, set beats clear
        setMask.overflowFlag = ovfEvt;
        setMask.compareFlag = matchEvt;
        clrMask = flagClrEn ? flagClrData : etc_flags_t'(FLAGS_RST);
        d.flags = (q.flags & ~clrMask) | setMask;

        // Masked requests
        d.ovfIrq = d.flags.overflowFlag
                   & d.mask.overflowFlag;
        d.cmpIrq = d.flags.compareFlag
                   & d.mask.compareFlag;

        // Top and bottom indications
        topVal = topOf(d.ctrl.waveformMode, d.compare);
        d.topInd = (d.counter == topVal);
        d.bottomInd = (d.counter == CNT_BOTTOM);
        if (topVal == CNT_BOTTOM) begin
            // Zero top: counter sits at both ends
            d.topInd = d.bottomInd;
        end
    end

    // State register, all zero after reset except bottom indication, which resets to one
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            q.counter <= CNT_RST;
            q.compare <= CMP_RST;
            q.compareBuf <= CMP_RST;
            q.ctrl <= etc_ctrl_t'(CTRL_RST);
            q.mask <= etc_flags_t'(MASK_RST);
            q.flags <= etc_flags_t'(FLAGS_RST);
            q.dirDown <= 1'b0;
            q.blockMatch <= 1'b0;
            q.pinOut <= 1'b0;
            q.topInd <= 1'b0;
            q.bottomInd <= 1'b1;
            q.ovfIrq <= 1'b0;
            q.cmpIrq <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from state
    assign counterValue = q.counter;
    assign compareValue = q.compareBuf;
    assign timerControlReg = q.ctrl;
    assign timerMaskReg = q.mask;
    assign timerFlagReg = q.flags;
    assign countDown = q.dirDown;
    assign topReached = q.topInd;
    assign bottomReached = q.bottomInd;
    assign overflowIrq = q.ovfIrq;
    assign compareIrq = q.cmpIrq;
    assign compareOutputPin = q.pinOut;

endmodule : etc_core

/* design/etc_edge_sync.sv */
`timescale 1ns/1ps

module etc_edge_sync (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Asynchronous pin
    input wire logic pinIn,
    // Edge pulses
    output logic riseEvt,
    output logic fallEvt
);
    import etc_pkg::*;

    // Two synchroniser stages, history, edge pulses
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
        logic rise;
        logic fall;
        logic [2:0] warm; // Real history once all ones
    } etc_sync_state_t;

    etc_sync_state_t q;
    etc_sync_state_t d;

    // First stage feeds only the second
    always_comb begin
        d = q;
        d.meta = pinIn;
        d.sync = q.meta;
        d.prev = q.sync;
        d.warm = {q.warm[1:0], 1'b1};
        d.rise = q.sync & ~q.prev & q.warm[2];
        d.fall = ~q.sync & q.prev & q.warm[2];
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign riseEvt = q.rise;
    assign fallEvt = q.fall;

endmodule : etc_edge_sync

/* design/etc_pkg.sv */
package etc_pkg;

    // Counter and compare width
    localparam int CNT_W = 8;

    // Count range landmarks
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] CNT_ONE = 8'h01;

    // Reset values
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [7:0] CMP_RST = 8'h00;
    localparam logic [6:0] CTRL_RST = 7'h00;
    localparam logic [1:0] FLAGS_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;

    // Flag and mask bit positions
    localparam int OVF_BIT = 0;
    localparam int CMP_BIT = 1;

    // Prescaler depth and divide ratios
    localparam int PRE_W = 10;
    localparam int DIV_A = 8;
    localparam int DIV_B = 64;
    localparam int DIV_C = 256;
    localparam int DIV_D = 1024;

    // Clock source and active edge
    typedef enum logic [2:0] {
        CS_STOP = 3'b000,
        CS_DIV1 = 3'b001,
        CS_DIV8 = 3'b010,
        CS_DIV64 = 3'b011,
        CS_DIV256 = 3'b100,
        CS_DIV1024 = 3'b101,
        CS_EXT_FALL = 3'b110,
        CS_EXT_RISE = 3'b111
    } etc_clksel_t;

    // Counting sequence
    typedef enum logic [1:0] {
        WM_NORMAL = 2'b00,
        WM_PHASE_PWM = 2'b01,
        WM_CLEAR_ON_COMPARE = 2'b10,
        WM_FAST_PWM = 2'b11
    } etc_wmode_t;

    // Pin action on compare match
    typedef enum logic [1:0] {
        OM_OFF = 2'b00,
        OM_TOGGLE = 2'b01,
        OM_CLEAR = 2'b10,
        OM_SET = 2'b11
    } etc_omode_t;

    // Timer control register layout
    typedef struct packed {
        etc_omode_t outMode;
        etc_wmode_t waveformMode;
        etc_clksel_t clockSelect;
    } etc_ctrl_t;

    // Flag and mask layout
    typedef struct packed {
        logic compareFlag;
        logic overflowFlag;
    } etc_flags_t;

    // Prescaled enable pulses
    typedef struct packed {
        logic div8;
        logic div64;
        logic div256;
        logic div1024;
    } etc_pre_ticks_t;

endpackage : etc_pkg

/* design/etc_prescaler.sv */
`timescale 1ns/1ps

module etc_prescaler #(
    parameter int PreW = etc_pkg::PRE_W
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Divided enable pulses
    output etc_pkg::etc_pre_ticks_t preTicks
);
    import etc_pkg::*;

    // Whole state of the divider
    typedef struct packed {
        logic [PreW-1:0] count;
        etc_pre_ticks_t ticks;
    } etc_pre_state_t;

    etc_pre_state_t q;
    etc_pre_state_t d;

    // One-cycle pulse when the low bits wrap
    function automatic logic wrapAt(input logic [PreW-1:0] c,
                                    input int div);
        logic [PreW-1:0] m;
        m = PreW'(div - 1);
        wrapAt = ((c & m) == m);
    endfunction : wrapAt

    // Free running count and tap decode
    always_comb begin
        d = q;
        d.count = q.count + PreW'(1);
        d.ticks.div8 = wrapAt(q.count, DIV_A);
        d.ticks.div64 = wrapAt(q.count, DIV_B);
        d.ticks.div256 = wrapAt(q.count, DIV_C);
        d.ticks.div1024 = wrapAt(q.count, DIV_D);
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign preTicks = q.ticks;

endmodule : etc_prescaler

/* dv/etc_core_bench.sv */
`timescale 1ns/1ps
module etc_core_bench;
    import etc_pkg::*;
    // One table row: setup, clock cycles, expected results
    typedef struct {
        etc_ctrl_t c;
        logic [7:0] s;
        logic [7:0] m;
        int n;
        logic [7:0] e;
        int tol;
        logic [1:0] fm;
        logic [1:0] ef;
    } etc_row_t;

    // Design inputs
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic extCountPin;
    logic cntWrEn = 1'b0;
    logic [7:0] cntWrData = 8'h00;
    logic cmpWrEn = 1'b0;
    logic [7:0] cmpWrData = 8'h00;
    logic ctrlWrEn = 1'b0;
    etc_ctrl_t ctrlWrData = '0;
    logic maskWrEn = 1'b0;
    etc_flags_t maskWrData = '0;
    logic flagClrEn = 1'b0;
    etc_flags_t flagClrData = '0;
    // Design outputs
    logic [7:0] counterValue;
    logic [7:0] compareValue;
    etc_ctrl_t timerControlReg;
    etc_flags_t timerMaskReg;
    etc_flags_t timerFlagReg;
    logic countDown;
    logic topReached;
    logic bottomReached;
    logic overflowIrq;
    logic compareIrq;
    logic compareOutputPin;
    // Bench state
    logic srcRun = 1'b0;
    logic [7:0] nRise = 8'h00;
    logic [7:0] nFall = 8'h00;
    logic [7:0] d;
    etc_row_t r;
    etc_row_t rows [12];
    int nErrors = 0;
    int checksDone = 0;

    // Free running clock
    always #2 core_clk = ~core_clk;

    // Edges sent on the count pin
    always @(posedge extCountPin) nRise = nRise + 8'h01;
    always @(negedge extCountPin) nFall = nFall + 8'h01;

    etc_core dut (.core_clk, .nrst, .extCountPin, .cntWrEn, .cntWrData,
        .cmpWrEn, .cmpWrData, .ctrlWrEn, .ctrlWrData, .maskWrEn,
        .maskWrData, .flagClrEn, .flagClrData, .counterValue,
        .compareValue, .timerControlReg, .timerMaskReg, .timerFlagReg,
        .countDown, .topReached, .bottomReached, .overflowIrq,
        .compareIrq, .compareOutputPin);

    etc_ext_src u_src (.core_clk, .run(srcRun), .halfPer(4'h4),
        .pin(extCountPin));

    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nErrors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Stopped setup, chosen source selected for n clock cycles, then stop
    task automatic run(input etc_ctrl_t c, input logic [7:0] s,
            input logic [7:0] m, input int n);
        etc_ctrl_t h;
        h = c;
        h.clockSelect = CS_STOP;
        @(posedge core_clk);
        ctrlWrEn <= 1'b1;
        ctrlWrData <= h;
        cntWrEn <= 1'b1;
        cntWrData <= s;
        cmpWrEn <= 1'b1;
        cmpWrData <= m;
        flagClrEn <= 1'b1;
        flagClrData <= 2'h3;
        @(posedge core_clk);
        cntWrEn <= 1'b0;
        cmpWrEn <= 1'b0;
        flagClrEn <= 1'b0;
        ctrlWrData <= c;
        repeat (n) @(posedge core_clk);
        ctrlWrData <= h;
        @(posedge core_clk);
        ctrlWrEn <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask : run

    // Verdict and end of run
    task automatic endSim;
        $display("checks=%0d errors=%0d", checksDone, nErrors);
        if (nErrors == 0 && checksDone > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : endSim

    // Cuts a hang short
    initial begin : watchdog
        #200000;
        nErrors++;
        endSim();
    end

    // Main sequence
    initial begin : main
        rows = '{
        '{'{OM_OFF,WM_NORMAL,CS_DIV1},8'h0e,8'h10,2,8'h10,0,2'h3,2'h0},
        '{'{OM_OFF,WM_NORMAL,CS_DIV1},8'h0e,8'h10,3,8'h11,0,2'h3,2'h2},
        '{'{OM_OFF,WM_NORMAL,CS_DIV1},8'h10,8'h10,1,8'h11,0,2'h3,2'h0},
        '{'{OM_OFF,WM_NORMAL,CS_DIV1},8'hfe,8'h10,2,8'h00,0,2'h3,2'h1},
        '{'{OM_OFF,WM_CLEAR_ON_COMPARE,CS_DIV1},8'h00,8'h03,5,8'h01,0,
            2'h3,2'h2},
        '{'{OM_OFF,WM_FAST_PWM,CS_DIV1},8'hfe,8'h80,2,8'h00,0,2'h1,2'h1},
        '{'{OM_OFF,WM_PHASE_PWM,CS_DIV1},8'hfd,8'h80,4,8'hfd,0,2'h1,2'h0},
        '{'{OM_OFF,WM_NORMAL,CS_DIV8},8'h00,8'h40,64,8'h08,1,2'h0,2'h0},
        '{'{OM_OFF,WM_NORMAL,CS_DIV64},8'h00,8'h40,256,8'h04,1,2'h0,2'h0},
        '{'{OM_OFF,WM_NORMAL,CS_DIV256},8'h00,8'h40,1024,8'h04,1,2'h0,
            2'h0},
        '{'{OM_OFF,WM_NORMAL,CS_DIV1024},8'h00,8'h40,2048,8'h02,1,2'h0,
            2'h0},
        '{'{OM_OFF,WM_NORMAL,CS_STOP},8'h5a,8'h5a,20,8'h5a,0,2'h3,2'h0}};
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        maskWrEn <= 1'b1;
        maskWrData <= 2'h3;
        @(posedge core_clk);
        maskWrEn <= 1'b0;
        // Table of ordinary cases
        foreach (rows[i]) begin
            r = rows[i];
            run(r.c, r.s, r.m, r.n);
            if (r.tol == 0) begin
                check(counterValue, r.e);
                check(8'(bottomReached), 8'(r.e == CNT_BOTTOM));
            end else begin
                d = counterValue - r.e;
                check(8'(d == 8'h00 || d == 8'h01 || d == 8'hff), 8'h01);
            end
            check(compareValue, r.m);
            d = (r.c.waveformMode == WM_CLEAR_ON_COMPARE) ? r.m : CNT_MAX;
            check(8'(topReached), 8'(counterValue == d));
            check(8'(timerFlagReg & r.fm), 8'(r.ef));
            check(8'({compareIrq, overflowIrq} & r.fm), 8'(r.ef));
            if (r.c.waveformMode == WM_PHASE_PWM) begin
                check(8'(countDown), 8'h01);
            end
        end
        // Masked overflow raises no request
        @(posedge core_clk);
        maskWrEn <= 1'b1;
        maskWrData <= 2'h0;
        @(posedge core_clk);
        maskWrEn <= 1'b0;
        run(etc_ctrl_t'{OM_OFF, WM_NORMAL, CS_DIV1}, 8'hfe, 8'h10, 2);
        check(8'(timerFlagReg), 8'h01);
        check(8'(overflowIrq), 8'h00);
        @(posedge core_clk);
        maskWrEn <= 1'b1;
        maskWrData <= 2'h3;
        @(posedge core_clk);
        maskWrEn <= 1'b0;
        flagClrEn <= 1'b1;
        flagClrData <= 2'h1;
        #1;
        check(8'(overflowIrq), 8'h01);
        @(posedge core_clk);
        flagClrEn <= 1'b0;
        #1;
        check(8'(overflowIrq), 8'h00);
        // Pin set then cleared on compare
        run(etc_ctrl_t'{OM_SET, WM_CLEAR_ON_COMPARE, CS_DIV1}, 8'h00,
            8'h03, 4);
        check(8'(compareOutputPin), 8'h01);
        run(etc_ctrl_t'{OM_CLEAR, WM_CLEAR_ON_COMPARE, CS_DIV1}, 8'h00,
            8'h03, 4);
        check(8'(compareOutputPin), 8'h00);
        // Counter write while ticking
        @(posedge core_clk);
        ctrlWrEn <= 1'b1;
        ctrlWrData <= etc_ctrl_t'{OM_OFF, WM_NORMAL, CS_DIV1};
        @(posedge core_clk);
        ctrlWrEn <= 1'b0;
        repeat (3) @(posedge core_clk);
        cntWrEn <= 1'b1;
        cntWrData <= 8'h77;
        @(posedge core_clk);
        cntWrEn <= 1'b0;
        #1;
        check(counterValue, 8'h77);
        @(posedge core_clk);
        #1;
        check(counterValue, 8'h78);
        // External pin, rising then falling edge
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk);
            ctrlWrEn <= 1'b1;
            ctrlWrData <= etc_ctrl_t'{OM_OFF, WM_NORMAL,
                (k == 0) ? CS_EXT_RISE : CS_EXT_FALL};
            cntWrEn <= 1'b1;
            cntWrData <= 8'h00;
            @(posedge core_clk);
            ctrlWrEn <= 1'b0;
            cntWrEn <= 1'b0;
            nRise = 8'h00;
            nFall = 8'h00;
            srcRun <= 1'b1;
            repeat (100) @(posedge core_clk);
            srcRun <= 1'b0;
            repeat (10) @(posedge core_clk);
            #1;
            check(counterValue, (k == 0) ? nRise : nFall);
        end
        // Second reset clears everything but bottom indication, which reads one
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        check(counterValue, 8'h00);
        check(compareValue, 8'h00);
        check(8'(timerControlReg), 8'h00);
        check(8'({timerMaskReg, timerFlagReg}), 8'h00);
        check(8'({bottomReached, compareOutputPin, overflowIrq,
            compareIrq}), 8'h08);
        @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        endSim();
    end
endmodule : etc_core_bench

/* dv/etc_core_props.sv */
`timescale 1ns/1ps
module etc_core_props
    import etc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Counter write port
    input wire logic cntWrEn,
    input wire logic [7:0] cntWrData,
    // Observed state
    input wire logic [7:0] counterValue,
    input wire logic [7:0] compareValue,
    input wire etc_pkg::etc_ctrl_t timerControlReg,
    input wire etc_pkg::etc_flags_t timerMaskReg,
    input wire etc_pkg::etc_flags_t timerFlagReg,
    input wire logic topReached,
    input wire logic bottomReached,
    input wire logic overflowIrq,
    input wire logic compareIrq
);
    // Live select and mode
    etc_clksel_t sel;
    etc_wmode_t mode;
    assign sel = timerControlReg.clockSelect;
    assign mode = timerControlReg.waveformMode;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    // Normal mode ticking every cycle, no write
    sequence s_run_normal;
        sel == CS_DIV1 && mode == WM_NORMAL && !cntWrEn;
    endsequence

    AST_STOP_HOLD: assert property (
        sel == CS_STOP && !cntWrEn |=> $stable(counterValue))
        else $error("counter moved while stopped");
    AST_WRITE_WINS: assert property (
        cntWrEn |=> counterValue == $past(cntWrData))
        else $error("counter write lost");
    AST_NORMAL_STEP: assert property (
        s_run_normal |=> counterValue == $past(counterValue) + 8'h01)
        else $error("normal mode did not add one");
    AST_OVF_WRAP: assert property (
        s_run_normal ##0 counterValue == CNT_MAX
        |=> timerFlagReg.overflowFlag && bottomReached)
        else $error("no overflow at wrap");
    AST_CTC_CLEAR: assert property (
        sel == CS_DIV1 && mode == WM_CLEAR_ON_COMPARE && !cntWrEn
        && counterValue == compareValue |=> counterValue == CNT_BOTTOM)
        else $error("no clear on compare");
    AST_OVF_IRQ: assert property (
        overflowIrq == (timerFlagReg.overflowFlag
        && timerMaskReg.overflowFlag))
        else $error("overflow request not flag and mask");
    AST_CMP_IRQ: assert property (
        compareIrq == (timerFlagReg.compareFlag
        && timerMaskReg.compareFlag))
        else $error("compare request not flag and mask");
    AST_MATCH_LATE: assert property (
        $rose(timerFlagReg.compareFlag)
        && $past(mode) inside {WM_NORMAL, WM_CLEAR_ON_COMPARE}
        |-> $past(counterValue) == $past(compareValue))
        else $error("compare flag without prior match");
    AST_BOTTOM_LVL: assert property (
        bottomReached == (counterValue == CNT_BOTTOM))
        else $error("bottom indication wrong");
    AST_TOP_MAX: assert property (
        mode == WM_NORMAL && $past(mode) == WM_NORMAL
        |-> topReached == (counterValue == CNT_MAX))
        else $error("top indication wrong in normal mode");

    // Main scenarios reached
    cover property ($rose(timerFlagReg.overflowFlag));
    cover property ($rose(timerFlagReg.compareFlag));
    cover property (mode == WM_PHASE_PWM && counterValue == CNT_MAX);
endmodule : etc_core_props

bind etc_core etc_core_props u_props (.core_clk, .nrst, .cntWrEn,
    .cntWrData, .counterValue, .compareValue, .timerControlReg,
    .timerMaskReg, .timerFlagReg, .topReached, .bottomReached,
    .overflowIrq, .compareIrq);

/* dv/etc_ext_src.sv */
`timescale 1ns/1ps
module etc_ext_src (
    // Clock
    input wire logic core_clk,
    // Run request and half period minus one, in clock cycles
    input wire logic run,
    input wire logic [3:0] halfPer,
    // Count pin toward the timer
    output logic pin
);
    // Cycle count within a half period
    logic [3:0] cnt;

    initial begin
        pin = 1'b0;
        cnt = 4'h0;
    end

    // Moves on the falling edge, away from the sampling edge
    always @(negedge core_clk) begin
        if (!run) begin
            cnt <= 4'h0;
        end else if (cnt == halfPer) begin
            cnt <= 4'h0;
            pin <= ~pin;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule : etc_ext_src
